// >>> psda_top.sv
// Program space data access: table reads and writes and the constant-data window,
// with an AXI4-Lite register slave for the page and control registers.
// Assumes program and data memories return read data one cycle after the strobe.
//
// Notes on behaviour
// - Word table read low returns program bits 15:0 as the data word.
// - Byte table read low puts one low-word byte in bits 7:0; select 1 upper.
// - Word table read high returns bits 23:16 low, upper data byte zero.
// - Byte table read high: select 0 gives upper byte, select 1 gives zero.
// - Program bits 23:16 reach data only via table read or write high.
// - Program address steps by two per 24-bit word; both halves share range.
// - Table page bit 7 clear is user memory, set is configuration memory.
// - Table address is table page over the 16-bit effective address.
// - Window redirect only with address bit 15 set and window enable set.
// - Visibility page picks one of 256 pages of 16K words.
// - Window ignores address bit 15; page bit 0 becomes program bit 15.
// - Data addresses 8000h upward map onto program memory when enabled.
// - Window reads return only the low 16 bits of the program word.
// - A window read stretches the instruction for the second fetch, except on steady repeat passes.
// - Window redirection is suspended during table reads and writes.
// - Outside repeat: move costs one extra cycle, others two.
// - In repeat: two extra on first, last, interrupt exit, re-entry; else none.
`timescale 1ns/100ps
`default_nettype none
module psda_top
  import psda_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire psda_kind_t  req_kind,
  input  wire logic        req_byte,
  input  wire logic [15:0] req_ea,
  input  wire logic [15:0] req_wdata,
  input  wire logic        req_move,
  input  wire logic        req_in_repeat,
  input  wire logic        req_rep_first,
  input  wire logic        req_rep_last,
  input  wire logic        req_rep_irq_exit,
  input  wire logic        req_rep_irq_reentry,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic [23:0]      pm_addr,
  output logic             pm_cfg,
  output logic             pm_rd,
  output logic             pm_wr,
  output logic [2:0]       pm_be,
  output logic [23:0]      pm_wdata,
  input  wire logic [23:0] pm_rdata,
  output logic [15:0]      dm_addr,
  output logic             dm_rd,
  output logic             dm_wr,
  output logic [1:0]       dm_be,
  output logic [15:0]      dm_wdata,
  input  wire logic [15:0] dm_rdata
);

  logic [7:0]  table_page_r;
  logic [7:0]  vis_page_r;
  logic [15:0] core_ctrl_r;
  psda_state_t state_r;
  psda_kind_t  kind_r;
  logic        byte_r;
  logic        sel_r;
  logic        win_r;
  logic        cfg_r;
  logic [1:0]  pen_r;
  logic [15:0] rdat_nxt;
  logic        done;
  logic        take;

  psda_map_if mif ();

  assign mif.kind       = req_kind;
  assign mif.ea         = req_ea;
  assign mif.table_page = table_page_r;
  assign mif.vis_page   = vis_page_r;
  assign mif.win_en     = core_ctrl_r[CTRL_WIN_EN_BIT];

  psda_map u_map (
    .m (mif.map)
  );

  // Read formatting of the 24-bit program word
  function automatic logic [15:0] fmt_pm(input psda_kind_t k, input logic bm,
                                         input logic sel, input logic [23:0] w);
    fmt_pm = w[15:0];
    if (k == KIND_TBL_RD_HI) begin
      if (!bm)
        fmt_pm = {8'h00, w[23:16]};
      else
        fmt_pm = sel ? 16'h0000 : {8'h00, w[23:16]};
    end else if (bm) begin
      fmt_pm = sel ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    end
  endfunction

  // Extra cycles of a window read
  function automatic logic [1:0] penalty(input logic mv, input logic rep,
                                         input logic edge_hit);
    if (!rep)
      penalty = mv ? PEN_MOVE : PEN_OTHER;
    else
      penalty = edge_hit ? PEN_REP_EDGE : PEN_REP_STEADY;
  endfunction

  assign req_ready = (state_r == ST_IDLE);
  assign take      = req_valid && req_ready;
  assign done      = ((state_r == ST_CAPTURE) && (pen_r == 2'h0)) ||
                     ((state_r == ST_STRETCH) && (pen_r == 2'h1));

  // Access sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take)
            state_r <= ST_ACCESS;
        end
        ST_ACCESS: begin
          state_r <= ST_CAPTURE;
        end
        ST_CAPTURE: begin
          state_r <= (pen_r == 2'h0) ? ST_IDLE : ST_STRETCH;
        end
        ST_STRETCH: begin
          if (pen_r == 2'h1)
            state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Latched request and stretch count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_r <= KIND_DATA_RD;
      byte_r <= 1'b0;
      sel_r  <= 1'b0;
      win_r  <= 1'b0;
      cfg_r  <= 1'b0;
      pen_r  <= 2'h0;
    end else if (take) begin
      kind_r <= req_kind;
      byte_r <= req_byte;
      sel_r  <= req_ea[0];
      win_r  <= mif.win_hit;
      cfg_r  <= mif.cfg_sel;
      if (mif.win_hit && (req_kind == KIND_DATA_RD))
        pen_r <= penalty(req_move, req_in_repeat,
                         req_rep_first | req_rep_last |
                         req_rep_irq_exit | req_rep_irq_reentry);
      else
        pen_r <= 2'h0;
    end else if (state_r == ST_STRETCH) begin
      pen_r <= pen_r - 2'h1;
    end
  end

  // Memory strobes, one cycle after the request is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pm_addr  <= 24'h000000;
      pm_cfg   <= 1'b0;
      pm_rd    <= 1'b0;
      pm_wr    <= 1'b0;
      pm_be    <= 3'h0;
      pm_wdata <= 24'h000000;
      dm_addr  <= 16'h0000;
      dm_rd    <= 1'b0;
      dm_wr    <= 1'b0;
      dm_be    <= 2'h0;
      dm_wdata <= 16'h0000;
    end else if (take) begin
      pm_addr  <= mif.pm_addr;
      pm_cfg   <= mif.cfg_sel;
      pm_rd    <= mif.use_pm && ((req_kind == KIND_DATA_RD) ||
                  (req_kind == KIND_TBL_RD_LO) || (req_kind == KIND_TBL_RD_HI));
      pm_wr    <= (req_kind == KIND_TBL_WT_LO) ||
                  ((req_kind == KIND_TBL_WT_HI) && !(req_byte && req_ea[0]));
      pm_wdata <= {req_wdata[7:0], req_byte ? {2{req_wdata[7:0]}} : req_wdata};
      if (req_kind == KIND_TBL_WT_HI)
        pm_be <= 3'h4;
      else if (req_kind == KIND_TBL_WT_LO)
        pm_be <= req_byte ? (req_ea[0] ? 3'h2 : 3'h1) : 3'h3;
      else
        pm_be <= 3'h0;
      dm_addr  <= req_ea;
      dm_rd    <= (req_kind == KIND_DATA_RD) && !mif.win_hit;
      dm_wr    <= (req_kind == KIND_DATA_WR) && !mif.win_hit;
      dm_be    <= req_byte ? (req_ea[0] ? 2'h2 : 2'h1) : 2'h3;
      dm_wdata <= req_byte ? {2{req_wdata[7:0]}} : req_wdata;
    end else begin
      pm_rd <= 1'b0;
      pm_wr <= 1'b0;
      dm_rd <= 1'b0;
      dm_wr <= 1'b0;
    end
  end

  // Read data selection
  always_comb begin
    rdat_nxt = 16'h0000;
    if ((kind_r == KIND_TBL_RD_LO) || (kind_r == KIND_TBL_RD_HI) ||
        ((kind_r == KIND_DATA_RD) && win_r))
      rdat_nxt = fmt_pm(kind_r, byte_r, sel_r, pm_rdata);
    else if (kind_r == KIND_DATA_RD)
      rdat_nxt = byte_r ? {8'h00, sel_r ? dm_rdata[15:8] : dm_rdata[7:0]} : dm_rdata;
  end

  // Answer to the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_data  <= 16'h0000;
      rsp_valid <= 1'b0;
    end else begin
      if (state_r == ST_CAPTURE)
        rsp_data <= rdat_nxt;
      rsp_valid <= done;
    end
  end

  // AXI4-Lite write channel: address and data taken together
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      table_page_r <= RST_TABLE_PAGE;
      vis_page_r   <= RST_VIS_PAGE;
      core_ctrl_r  <= RST_CORE_CTRL;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (s_axi_awready) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= RESP_OKAY;
      if (s_axi_awaddr == OFF_TABLE_PAGE) begin
        if (s_axi_wstrb[0])
          table_page_r <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == OFF_VIS_PAGE) begin
        if (s_axi_wstrb[0])
          vis_page_r <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == OFF_CORE_CTRL) begin
        if (s_axi_wstrb[0])
          core_ctrl_r[7:0] <= s_axi_wdata[7:0];
        if (s_axi_wstrb[1])
          core_ctrl_r[15:8] <= s_axi_wdata[15:8];
      end else if (s_axi_awaddr != OFF_STATUS) begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      if (s_axi_araddr == OFF_TABLE_PAGE) begin
        s_axi_rdata[7:0] <= table_page_r;
      end else if (s_axi_araddr == OFF_VIS_PAGE) begin
        s_axi_rdata[7:0] <= vis_page_r;
      end else if (s_axi_araddr == OFF_CORE_CTRL) begin
        s_axi_rdata[15:0] <= core_ctrl_r;
      end else if (s_axi_araddr == OFF_STATUS) begin
        s_axi_rdata[ST_BUSY_BIT] <= (state_r != ST_IDLE);
        s_axi_rdata[ST_WIN_BIT]  <= win_r;
        s_axi_rdata[ST_CFG_BIT]  <= cfg_r;
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // psda_top
`default_nettype wire

// >>> psda_pkg.sv
// Package for the program space data access block: register map, field positions,
// reset values, access kinds, states and cycle penalties.
// Assumes a 16-bit data side and a 24-bit program memory word.
package psda_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0]  OFF_TABLE_PAGE = 8'h00;
  localparam logic [7:0]  OFF_VIS_PAGE   = 8'h04;
  localparam logic [7:0]  OFF_CORE_CTRL  = 8'h08;
  localparam logic [7:0]  OFF_STATUS     = 8'h0C;

  // Reset values
  localparam logic [7:0]  RST_TABLE_PAGE = 8'h00;
  localparam logic [7:0]  RST_VIS_PAGE   = 8'h00;
  localparam logic [15:0] RST_CORE_CTRL  = 16'h0000;

  // Field positions
  localparam int CTRL_WIN_EN_BIT = 2;
  localparam int CFG_SPACE_BIT   = 7;
  localparam int WIN_EA_BIT      = 15;
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_WIN_BIT      = 1;
  localparam int ST_CFG_BIT      = 2;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // Extra cycles for a window read
  localparam logic [1:0]  PEN_MOVE       = 2'h1;
  localparam logic [1:0]  PEN_OTHER      = 2'h2;
  localparam logic [1:0]  PEN_REP_EDGE   = 2'h2;
  localparam logic [1:0]  PEN_REP_STEADY = 2'h0;

  typedef enum logic [2:0] {
    KIND_DATA_RD,
    KIND_DATA_WR,
    KIND_TBL_RD_LO,
    KIND_TBL_RD_HI,
    KIND_TBL_WT_LO,
    KIND_TBL_WT_HI
  } psda_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_CAPTURE,
    ST_STRETCH
  } psda_state_t;

endpackage

// >>> psda_map_if.sv
// Carrier between the access sequencer and the address mapper.
// Assumes the mapper is purely combinational.
`timescale 1ns/100ps
`default_nettype none
interface psda_map_if;
  import psda_pkg::*;
  psda_kind_t  kind;
  logic [15:0] ea;
  logic [7:0]  table_page;
  logic [7:0]  vis_page;
  logic        win_en;
  logic        use_pm;
  logic        win_hit;
  logic        cfg_sel;
  logic [23:0] pm_addr;

  modport seq (output kind, ea, table_page, vis_page, win_en,
               input use_pm, win_hit, cfg_sel, pm_addr);
  modport map (input kind, ea, table_page, vis_page, win_en,
               output use_pm, win_hit, cfg_sel, pm_addr);
endinterface
`default_nettype wire

// >>> psda_map.sv
// Program address mapper for table accesses and the constant-data window.
// Assumes request fields on the carrier are stable while they are sampled.
`timescale 1ns/100ps
`default_nettype none
module psda_map
  import psda_pkg::*;
(
  psda_map_if.map m
);

  function automatic logic is_table(input psda_kind_t k);
    is_table = (k != KIND_DATA_RD) && (k != KIND_DATA_WR);
  endfunction

  always_comb begin
    m.win_hit = 1'b0;
    m.use_pm  = 1'b0;
    m.cfg_sel = 1'b0;
    m.pm_addr = 24'h000000;
    if (is_table(m.kind)) begin
      m.use_pm  = 1'b1;
      m.pm_addr = {m.table_page, m.ea};
      m.cfg_sel = m.table_page[CFG_SPACE_BIT];
    end else if (m.ea[WIN_EA_BIT] && m.win_en) begin
      m.win_hit = 1'b1;
      m.use_pm  = (m.kind == KIND_DATA_RD);
      m.pm_addr = {1'b0, m.vis_page, m.ea[14:0]};
    end
  end

endmodule // psda_map
`default_nettype wire

// >>> psda_props.sv
// Checker bound to psda_top: table and window address mapping, window timing.
// Assumes page registers are not written in the cycle a request is taken.
`timescale 1ns/100ps
`default_nettype none
module psda_props
  import psda_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire psda_kind_t  req_kind,
  input wire logic [15:0] req_ea,
  input wire logic        req_move,
  input wire logic        req_in_repeat,
  input wire logic        req_rep_first,
  input wire logic        req_rep_last,
  input wire logic        req_rep_irq_exit,
  input wire logic        req_rep_irq_reentry,
  input wire logic        rsp_valid,
  input wire logic [23:0] pm_addr,
  input wire logic        pm_cfg,
  input wire logic        pm_rd,
  input wire logic        dm_rd,
  input wire logic        dm_wr
);
  logic [7:0]  tp_r;
  logic [7:0]  vp_r;
  logic        en_r;
  logic        take, tbl, win, occ, cfg;
  logic [14:0] ea_lo;
  assign take  = req_valid && req_ready;
  assign tbl   = take && (req_kind == KIND_TBL_RD_LO || req_kind == KIND_TBL_RD_HI);
  assign win   = take && req_kind == KIND_DATA_RD && req_ea[WIN_EA_BIT] && en_r;
  assign occ   = req_rep_first || req_rep_last || req_rep_irq_exit || req_rep_irq_reentry;
  assign cfg   = tp_r[CFG_SPACE_BIT];
  assign ea_lo = req_ea[14:0];
  // Shadow of the page and control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tp_r <= 8'h00;
      vp_r <= 8'h00;
      en_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      if (s_axi_awaddr == OFF_TABLE_PAGE) tp_r <= s_axi_wdata[7:0];
      if (s_axi_awaddr == OFF_VIS_PAGE) vp_r <= s_axi_wdata[7:0];
      if (s_axi_awaddr == OFF_CORE_CTRL) en_r <= s_axi_wdata[CTRL_WIN_EN_BIT];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_quiet2; !rsp_valid [*2]; endsequence
  sequence s_quiet3; !rsp_valid [*3]; endsequence
  a_tbl_addr: assert property (
    tbl |=> pm_rd && pm_addr == {$past(tp_r), $past(req_ea)}) else $error("table address");
  a_cfg_select: assert property (
    tbl |=> pm_cfg == $past(cfg)) else $error("config select");
  a_win_addr: assert property (
    win |=> pm_rd && pm_addr == {1'b0, $past(vp_r), $past(ea_lo)}) else $error("window address");
  a_plain_data: assert property (
    take && req_kind == KIND_DATA_RD && !win |=> dm_rd && !pm_rd) else $error("plain read");
  a_data_write: assert property (
    take && req_kind == KIND_DATA_WR && !(req_ea[WIN_EA_BIT] && en_r) |=> dm_wr && !pm_rd)
    else $error("plain write");
  a_move_extra: assert property (
    win && req_move && !req_in_repeat |=> s_quiet3 ##1 rsp_valid) else $error("move cycles");
  a_other_extra: assert property (
    win && !req_move && !req_in_repeat |=> s_quiet3 ##1 !rsp_valid ##1 rsp_valid)
    else $error("other cycles");
  a_rep_edge: assert property (
    win && req_in_repeat && occ |=> s_quiet3 ##1 !rsp_valid ##1 rsp_valid) else $error("rep edge");
  a_rep_steady: assert property (
    win && req_in_repeat && !occ |=> s_quiet2 ##1 rsp_valid) else $error("rep steady");
endmodule // psda_props
bind psda_top psda_props psda_props_i (.*);
`default_nettype wire

// >>> psda_mem.sv
// Program and data memory model facing psda_top; records the last program reads and writes.
// Assumes one-cycle strobes; read data follows one cycle later.
`timescale 1ns/100ps
`default_nettype none
module psda_mem (
  input wire logic        aclk,
  input wire logic [23:0] pm_addr,
  input wire logic        pm_cfg,
  input wire logic        pm_rd,
  input wire logic        pm_wr,
  input wire logic [2:0]  pm_be,
  input wire logic [23:0] pm_wdata,
  output logic     [23:0] pm_rdata,
  input wire logic [15:0] dm_addr,
  input wire logic        dm_rd,
  output logic     [15:0] dm_rdata,
  output logic     [23:0] lr_addr,
  output logic            lr_cfg,
  output logic     [23:0] lw_addr,
  output logic     [23:0] lw_data,
  output logic     [2:0]  lw_be
);
  initial {pm_rdata, dm_rdata, lr_addr, lr_cfg, lw_addr, lw_data, lw_be} = '0;
  // Idle read lines toggle so stale data is never mistaken for an answer
  always @(posedge aclk) begin
    pm_rdata <= pm_rd ? {{8{pm_addr[1]}}, {pm_addr[15:1], 1'b0} ^ 16'h5AA5} : ~pm_rdata;
    dm_rdata <= dm_rd ? dm_addr ^ 16'h0F0F : ~dm_rdata;
    if (pm_rd) {lr_addr, lr_cfg} <= {pm_addr, pm_cfg};
    if (pm_wr) {lw_addr, lw_data, lw_be} <= {pm_addr, pm_wdata, pm_be};
  end
endmodule // psda_mem
`default_nettype wire

// >>> psda_tb.sv
// Bench for psda_top: registers over AXI4-Lite, table reads and writes, window.
// Assumes psda_mem answers each strobe one cycle later.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import psda_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, req_valid = 1'b0, req_byte = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, dm_be, rs;
  psda_kind_t  req_kind = KIND_DATA_RD;
  logic [15:0] req_ea = 16'h0, req_wdata = 16'h0, rsp_data, dm_addr, dm_wdata, dm_rdata, d;
  logic        req_move = 1'b0, req_in_repeat = 1'b0, req_rep_first = 1'b0;
  logic        req_rep_last = 1'b0, req_rep_irq_exit = 1'b0, req_rep_irq_reentry = 1'b0;
  logic        req_ready, rsp_valid, pm_cfg, pm_rd, pm_wr, dm_rd, dm_wr, lr_cfg;
  logic [23:0] pm_addr, pm_wdata, pm_rdata, lr_addr, lw_addr, lw_data, p;
  logic [2:0]  pm_be, lw_be;
  int          errors = 0, tests_run = 0, n;
  psda_top psda_top_i (.*);
  psda_mem psda_mem_i (.*);
  always #20 aclk = ~aclk;
  function automatic logic [23:0] pw(input logic [23:0] x);
    return {{8{x[1]}}, {x[15:1], 1'b0} ^ 16'h5AA5};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {ad, dt, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(posedge aclk); while (!s_axi_awready);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    while (!s_axi_bvalid) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] ad);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    {rd, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic core(input psda_kind_t k, input logic b, input logic [15:0] ea,
                      input logic [15:0] wd, input logic mv, input logic [4:0] rp);
    @(posedge aclk);
    {req_valid, req_byte, req_ea, req_wdata, req_move} <= {1'b1, b, ea, wd, mv};
    req_kind <= k;
    {req_in_repeat, req_rep_first, req_rep_last, req_rep_irq_exit, req_rep_irq_reentry} <= rp;
    do @(posedge aclk); while (!req_ready);
    req_valid <= 1'b0;
    n = 0;
    do begin @(posedge aclk); n++; end while (!rsp_valid && n < 50);
    // A missing answer counts as a mismatch
    chk("rsp_valid", 32'h1, 32'(rsp_valid));
    d = rsp_data;
  endtask
  task automatic give_verdict;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge aclk);
    errors++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      axr(8'(i * 4));
      chk("reg reset", 32'h0, rd);
    end
    axr(8'h10);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rs));
    axw(8'h10, 32'h1);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rs));
    axw(OFF_TABLE_PAGE, 32'h12);
    axr(OFF_TABLE_PAGE);
    chk("table page", 32'h12, rd);
    p = pw(24'h123456);
    core(KIND_TBL_RD_LO, 1'b0, 16'h3456, 16'h0, 1'b0, 5'h0);
    chk("rdlo word", 32'(p[15:0]), 32'(d));
    chk("rdlo addr", 32'h123456, 32'(lr_addr));
    chk("user space", 32'h0, 32'(lr_cfg));
    core(KIND_TBL_RD_LO, 1'b1, 16'h3456, 16'h0, 1'b0, 5'h0);
    chk("rdlo b0", 32'(p[7:0]), 32'(d[7:0]));
    core(KIND_TBL_RD_LO, 1'b1, 16'h3457, 16'h0, 1'b0, 5'h0);
    chk("rdlo b1", 32'(p[15:8]), 32'(d[7:0]));
    core(KIND_TBL_RD_HI, 1'b0, 16'h3456, 16'h0, 1'b0, 5'h0);
    chk("rdhi word", 32'(p[23:16]), 32'(d));
    core(KIND_TBL_RD_HI, 1'b1, 16'h3456, 16'h0, 1'b0, 5'h0);
    chk("rdhi b0", 32'(p[23:16]), 32'(d[7:0]));
    core(KIND_TBL_RD_HI, 1'b1, 16'h3457, 16'h0, 1'b0, 5'h0);
    chk("rdhi b1", 32'h0, 32'(d));
    core(KIND_TBL_WT_LO, 1'b0, 16'h0020, 16'hBEEF, 1'b0, 5'h0);
    chk("wtlo", 32'h0020_BEEF, {lw_addr[15:0], lw_data[15:0]});
    chk("wtlo addr", 32'h120020, 32'(lw_addr));
    chk("wtlo be", 32'h3, 32'(lw_be));
    core(KIND_TBL_WT_HI, 1'b0, 16'h0020, 16'h00AB, 1'b0, 5'h0);
    chk("wthi", 32'hAB, 32'(lw_data[23:16]));
    chk("wthi be", 32'h4, 32'(lw_be));
    axw(OFF_TABLE_PAGE, 32'h85);
    axw(OFF_VIS_PAGE, 32'h02);
    axw(OFF_CORE_CTRL, 32'h4);
    core(KIND_TBL_RD_LO, 1'b0, 16'hC124, 16'h0, 1'b0, 5'h0);
    chk("cfg space", 32'h1, 32'(lr_cfg));
    chk("no window", 32'h85C124, 32'(lr_addr));
    p = pw(24'h014124);
    core(KIND_DATA_RD, 1'b0, 16'hC124, 16'h0, 1'b1, 5'h0);
    chk("win data", 32'(p[15:0]), 32'(d));
    chk("win addr", 32'h014124, 32'(lr_addr));
    chk("move cycles", 32'd4, 32'(n));
    core(KIND_DATA_RD, 1'b0, 16'hC124, 16'h0, 1'b0, 5'h0);
    chk("other cycles", 32'd5, 32'(n));
    core(KIND_DATA_RD, 1'b0, 16'hC124, 16'h0, 1'b1, 5'h10);
    chk("rep steady", 32'd3, 32'(n));
    for (int i = 0; i < 4; i++) begin
      core(KIND_DATA_RD, 1'b0, 16'hC124, 16'h0, 1'b1, 5'h10 | (5'h1 << i));
      chk("rep edge", 32'd5, 32'(n));
    end
    core(KIND_DATA_RD, 1'b0, 16'h8000, 16'h0, 1'b1, 5'h0);
    chk("win base", 32'h010000, 32'(lr_addr));
    axr(OFF_STATUS);
    chk("status", 32'h2, rd);
    core(KIND_DATA_RD, 1'b0, 16'h7FFE, 16'h0, 1'b1, 5'h0);
    chk("below win", 32'h70F1, 32'(d));
    axw(OFF_CORE_CTRL, 32'h0);
    core(KIND_DATA_RD, 1'b0, 16'hC124, 16'h0, 1'b1, 5'h0);
    chk("win off", 32'hCE2B, 32'(d));
    chk("no fetch", 32'h010000, 32'(lr_addr));
    core(KIND_DATA_WR, 1'b0, 16'hC124, 16'h1234, 1'b0, 5'h0);
    chk("write answer", 32'h0, 32'(d));
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
